//--- design/dgc_config.sv
`timescale 1ns/1ps
module dgc_config #(
    parameter int NCH   = 6,
    parameter int LIMIT = dgc_pkg::TIMEOUT_CYCLES
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // I/O-space register access
    input  wire logic              io_wr,
    input  wire logic              io_rd,
    input  wire logic [7:0]        io_addr,
    input  wire logic [15:0]       io_wdata,
    output logic      [15:0]       io_rdata,
    output logic                   io_rvalid,
    // index lookup from the transfer engine
    input  wire logic [2:0]        idx_chan,
    output logic      [15:0]       src_elem_idx,
    output logic      [15:0]       src_frame_idx,
    output logic      [15:0]       dst_elem_idx,
    output logic      [15:0]       dst_frame_idx,
    // per-channel configuration
    output logic      [NCH-1:0]    ch_enable,
    output logic      [NCH-1:0]    ch_priority,
    output logic      [NCH-1:0]    ch_frame_sync,
    output logic      [NCH-1:0]    ch_auto_reload,
    output logic      [NCH-1:0]    ch_repeat,
    output logic      [NCH-1:0]    ch_end_prog,
    output logic      [NCH-1:0]    ch_dst_const,
    output logic      [NCH*2-1:0]  ch_src_mode,
    output logic      [NCH*2-1:0]  ch_dst_mode,
    output logic      [NCH*5-1:0]  ch_sync_event,
    // RAM port request waits and time-out errors
    input  wire logic              dual_ram_wait,
    input  wire logic              single_ram_wait,
    output logic                   dual_ram_timeout_err,
    output logic                   single_ram_timeout_err
);
    // ========================================================
    // state
    typedef struct packed {
        logic                  dest_index_source_select;
        logic                  dual_ram_timeout_en;
        logic                  single_ram_timeout_en;
        logic [NCH-1:0][15:0]  channel_control;
        logic [15:0]           rdata;
        logic                  rvalid;
        logic                  rd_mem;
        logic [1:0]            lk_phase;
        logic [1:0]            lk_phase_d1;
        logic                  lk_used;
        logic [15:0]           src_e;
        logic [15:0]           src_f;
        logic [15:0]           dst_e;
        logic [15:0]           dst_f;
    } dgc_cfg_reg_t;

    dgc_cfg_reg_t r_q;
    dgc_cfg_reg_t r_d;

    // ========================================================
    // address decode
    logic        in_chan;
    logic [7:0]  chan_off;
    logic [2:0]  chan_num;
    logic [2:0]  chan_slot;
    logic        slot_is_step;
    logic [1:0]  step_kind;

    assign in_chan      = (io_addr >= dgc_pkg::OFS_CHAN_BASE);
    assign chan_off     = io_addr - dgc_pkg::OFS_CHAN_BASE;
    assign chan_num     = chan_off[5:3];
    assign chan_slot    = chan_off[2:0];
    assign slot_is_step = (chan_slot >= dgc_pkg::SLOT_SRC_ELEM) &&
                          (chan_slot <= dgc_pkg::SLOT_DST_FRAME);
    assign step_kind    = 2'(chan_slot - dgc_pkg::SLOT_SRC_ELEM);

    logic        chan_ok;
    logic        rd_step;
    assign chan_ok = in_chan && (32'(chan_num) < NCH) &&
                     (chan_off < 8'(NCH * int'(dgc_pkg::OFS_CHAN_STRIDE)));
    // an io read of an index slot borrows the memory port for one cycle
    assign rd_step = io_rd && chan_ok && slot_is_step;

    // ========================================================
    // index memory: four words per channel, address {chan, kind}
    logic        mem_we;
    logic [4:0]  mem_waddr;
    logic [4:0]  mem_raddr;
    logic [15:0] mem_rdata;
    logic [1:0]  lk_kind;

    assign mem_we    = io_wr && chan_ok && slot_is_step;
    assign mem_waddr = {chan_num, step_kind};

    // io reads of index slots get the port; otherwise cycle through the lookup words
    always_comb begin
        lk_kind = r_q.lk_phase;
        // compatibility mode reuses the source words for the destination
        if (!r_q.dest_index_source_select) begin
            lk_kind = {1'b0, r_q.lk_phase[0]};
        end
        if (rd_step) begin
            mem_raddr = {chan_num, step_kind};
        end else begin
            mem_raddr = {idx_chan, lk_kind};
        end
    end

    dgc_step_mem #(
        .AW (5),
        .DW (16)
    ) u_mem (
        .clk   (clk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (io_wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // ========================================================
    // next state
    always_comb begin
        r_d = r_q;
        r_d.rvalid      = io_rd;
        r_d.rd_mem      = rd_step;
        // lookup walk pauses while an io read holds the memory port
        r_d.lk_phase_d1 = r_q.lk_phase;
        r_d.lk_used     = !rd_step;
        if (!rd_step) begin
            r_d.lk_phase = r_q.lk_phase + 2'h1;
        end
        if (io_wr) begin
            if (io_addr == dgc_pkg::OFS_INDEX_MODE) begin
                r_d.dest_index_source_select =
                    io_wdata[dgc_pkg::IDX_MODE_BIT];
            end
            if (io_addr == dgc_pkg::OFS_TIMEOUT_EN) begin
                r_d.dual_ram_timeout_en   = io_wdata[dgc_pkg::TO_DUAL_BIT];
                r_d.single_ram_timeout_en = io_wdata[dgc_pkg::TO_SINGLE_BIT];
            end
            if (chan_ok && chan_slot == dgc_pkg::SLOT_CTRL) begin
                // bit 10 stored as written; software keeps it zero
                r_d.channel_control[chan_num] = io_wdata;
            end
        end
        r_d.rdata = dgc_pkg::RST_WORD;
        if (io_rd) begin
            if (io_addr == dgc_pkg::OFS_INDEX_MODE) begin
                r_d.rdata = {15'h0000, r_q.dest_index_source_select} &
                            dgc_pkg::MASK_IDX_MODE;
            end else if (io_addr == dgc_pkg::OFS_TIMEOUT_EN) begin
                r_d.rdata = {14'h0000, r_q.dual_ram_timeout_en,
                             r_q.single_ram_timeout_en} & dgc_pkg::MASK_TIMEOUT;
            end else if (chan_ok && chan_slot == dgc_pkg::SLOT_CTRL) begin
                r_d.rdata = r_q.channel_control[chan_num];
            end
        end
        // collect the lookup word fetched last cycle
        if (r_q.lk_used) begin
            case (r_q.lk_phase_d1)
                2'h0: r_d.src_e = mem_rdata;
                2'h1: r_d.src_f = mem_rdata;
                2'h2: r_d.dst_e = mem_rdata;
                2'h3: r_d.dst_f = mem_rdata;
                default: r_d.src_e = mem_rdata;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // ========================================================
    // outputs
    assign io_rdata      = r_q.rd_mem ? mem_rdata : r_q.rdata;
    assign io_rvalid     = r_q.rvalid;
    assign src_elem_idx  = r_q.src_e;
    assign src_frame_idx = r_q.src_f;
    assign dst_elem_idx  = r_q.dst_e;
    assign dst_frame_idx = r_q.dst_f;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic [15:0] cc;
            assign cc = r_q.channel_control[g];
            assign ch_dst_mode[2*g +: 2]   = cc[dgc_pkg::CC_DST_MODE_HI:
                                               dgc_pkg::CC_DST_MODE_LO];
            assign ch_src_mode[2*g +: 2]   = cc[dgc_pkg::CC_SRC_MODE_HI:
                                               dgc_pkg::CC_SRC_MODE_LO];
            assign ch_dst_const[g]         = (cc[dgc_pkg::CC_DST_MODE_HI:
                                               dgc_pkg::CC_DST_MODE_LO]
                                              == dgc_pkg::AMODE_CONST);
            assign ch_end_prog[g]          = cc[dgc_pkg::CC_END_PROG];
            assign ch_repeat[g]            = cc[dgc_pkg::CC_REPEAT];
            assign ch_auto_reload[g]       = cc[dgc_pkg::CC_AUTO_RELOAD];
            assign ch_enable[g]            = cc[dgc_pkg::CC_ENABLE];
            assign ch_priority[g]          = cc[dgc_pkg::CC_PRIORITY];
            assign ch_frame_sync[g]        = cc[dgc_pkg::CC_FRAME_SYNC];
            assign ch_sync_event[5*g +: 5] = cc[dgc_pkg::CC_EVENT_HI:
                                               dgc_pkg::CC_EVENT_LO];
        end
    endgenerate

    // ========================================================
    // time-out watches; request waits come from the engine on this same clock
    dgc_timeout #(
        .LIMIT (LIMIT)
    ) u_dual_to (
        .clk      (clk),
        .rst      (rst),
        .enable   (r_q.dual_ram_timeout_en),
        .req_wait (dual_ram_wait),
        .err      (dual_ram_timeout_err)
    );

    dgc_timeout #(
        .LIMIT (LIMIT)
    ) u_single_to (
        .clk      (clk),
        .rst      (rst),
        .enable   (r_q.single_ram_timeout_en),
        .req_wait (single_ram_wait),
        .err      (single_ram_timeout_err)
    );
endmodule

//--- design/dgc_pkg.sv
package dgc_pkg;
    // ========================================================
    // register offsets (I/O word addresses)
    localparam logic [7:0] OFS_INDEX_MODE = 8'h00;
    localparam logic [7:0] OFS_TIMEOUT_EN = 8'h01;
    localparam logic [7:0] OFS_STEP_BASE  = 8'h10;
    localparam logic [7:0] OFS_CHAN_BASE  = 8'h40;
    // per-channel stride of the channel register windows
    localparam logic [7:0] OFS_CHAN_STRIDE = 8'h08;
    // control and index slots inside a channel window
    localparam logic [2:0] SLOT_CTRL      = 3'h0;
    localparam logic [2:0] SLOT_SRC_ELEM  = 3'h1;
    localparam logic [2:0] SLOT_SRC_FRAME = 3'h2;
    localparam logic [2:0] SLOT_DST_ELEM  = 3'h3;
    localparam logic [2:0] SLOT_DST_FRAME = 3'h4;

    // ========================================================
    // field positions
    localparam int IDX_MODE_BIT   = 0;
    localparam int TO_SINGLE_BIT  = 0;
    localparam int TO_DUAL_BIT    = 1;
    localparam int CC_DST_MODE_HI = 15;
    localparam int CC_DST_MODE_LO = 14;
    localparam int CC_SRC_MODE_HI = 13;
    localparam int CC_SRC_MODE_LO = 12;
    localparam int CC_END_PROG    = 11;
    localparam int CC_RSVD        = 10;
    localparam int CC_REPEAT      = 9;
    localparam int CC_AUTO_RELOAD = 8;
    localparam int CC_ENABLE      = 7;
    localparam int CC_PRIORITY    = 6;
    localparam int CC_FRAME_SYNC  = 5;
    localparam int CC_EVENT_HI    = 4;
    localparam int CC_EVENT_LO    = 0;

    // ========================================================
    // reset values, masks and the constant address mode code
    localparam logic [15:0] RST_WORD      = 16'h0000;
    localparam logic [15:0] MASK_IDX_MODE = 16'h0001;
    localparam logic [15:0] MASK_TIMEOUT  = 16'h0003;
    localparam logic [1:0]  AMODE_CONST   = 2'h0;

    // ========================================================
    // time-out limit
    localparam int TIMEOUT_NS     = 1000;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TIMEOUT_CYCLES = TIMEOUT_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        TO_IDLE  = 2'b00,
        TO_COUNT = 2'b01,
        TO_ERR   = 2'b10
    } dgc_to_state_t;
endpackage

//--- design/dgc_step_mem.sv
`timescale 1ns/1ps
// small register-file memory for the per-channel index words
module dgc_step_mem #(
    parameter int AW = 5,
    parameter int DW = 16
) (
    // clock
    input  wire logic          clk,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // read port, registered
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    // no reset: software must load indexes before enabling a channel
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

//--- design/dgc_timeout.sv
`timescale 1ns/1ps
// one RAM port's request time-out watch
module dgc_timeout #(
    parameter int LIMIT = dgc_pkg::TIMEOUT_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control
    input  wire logic enable,
    input  wire logic req_wait,
    // result
    output logic      err
);
    typedef struct packed {
        dgc_pkg::dgc_to_state_t st;
        logic [15:0]            cnt;
        logic                   err;
    } dgc_to_reg_t;

    dgc_to_reg_t r_q;
    dgc_to_reg_t r_d;

    always_comb begin
        r_d = r_q;
        r_d.err = 1'b0;
        case (r_q.st)
            dgc_pkg::TO_IDLE: begin
                r_d.cnt = 16'h0000;
                if (enable && req_wait) begin
                    r_d.st = dgc_pkg::TO_COUNT;
                end
            end
            dgc_pkg::TO_COUNT: begin
                if (!enable || !req_wait) begin
                    r_d.st = dgc_pkg::TO_IDLE;
                end else if (r_q.cnt >= 16'(LIMIT - 1)) begin
                    r_d.st  = dgc_pkg::TO_ERR;
                    r_d.err = 1'b1;
                end else begin
                    r_d.cnt = r_q.cnt + 16'h0001;
                end
            end
            dgc_pkg::TO_ERR: begin
                // one error per waiting request
                if (!req_wait || !enable) begin
                    r_d.st = dgc_pkg::TO_IDLE;
                end
            end
            default: r_d.st = dgc_pkg::TO_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_q <= '{st: dgc_pkg::TO_IDLE, cnt: 16'h0000, err: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    assign err = r_q.err;
endmodule

//--- verification/dgc_props.sv
`timescale 1ns/1ps
module dgc_props #(
    parameter int NCH   = 6,
    parameter int LIMIT = dgc_pkg::TIMEOUT_CYCLES
) (
    // clock and reset
    input wire logic             clk,
    input wire logic             rst,
    // register access
    input wire logic             io_wr,
    input wire logic             io_rd,
    input wire logic [7:0]       io_addr,
    input wire logic [15:0]      io_wdata,
    input wire logic [15:0]      io_rdata,
    input wire logic             io_rvalid,
    // channel configuration
    input wire logic [NCH-1:0]   ch_enable,
    input wire logic [NCH*2-1:0] ch_dst_mode,
    input wire logic [NCH-1:0]   ch_dst_const,
    input wire logic [NCH*5-1:0] ch_sync_event,
    // time-out watch
    input wire logic             dual_ram_wait,
    input wire logic             single_ram_wait,
    input wire logic             dual_ram_timeout_err,
    input wire logic             single_ram_timeout_err
);
    // lower bound assumes LIMIT of at least 8
    localparam int LO = LIMIT - 8;
    localparam int HI = LIMIT - 6;
    logic [15:0] wd_q;
    logic        dual_en_q;
    logic        single_en_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ========================================================
    // shadow of the enables, rebuilt from bus writes only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wd_q        <= 16'h0000;
            dual_en_q   <= 1'b0;
            single_en_q <= 1'b0;
        end else begin
            wd_q <= io_wdata;
            if (io_wr && io_addr == dgc_pkg::OFS_TIMEOUT_EN) begin
                dual_en_q   <= io_wdata[1];
                single_en_q <= io_wdata[0];
            end
        end
    end

    sequence s_dual_long_wait;
        dual_en_q && $rose(dual_ram_wait) ##1 (dual_en_q && dual_ram_wait) [*8];
    endsequence

    // ========================================================
    // properties
    a_rd_answered: assert property (io_rd |=> io_rvalid)
        else $error("read strobe not answered");
    a_no_stray_rvalid: assert property (!io_rd |=> !io_rvalid)
        else $error("read valid without a read");
    a_idx_upper_zero: assert property (io_rd && io_addr == dgc_pkg::OFS_INDEX_MODE
        |=> io_rdata[15:1] == 15'h0000) else $error("index mode upper bits not zero");
    a_to_upper_zero: assert property (io_rd && io_addr == dgc_pkg::OFS_TIMEOUT_EN
        |=> io_rdata[15:2] == 14'h0000) else $error("time-out upper bits not zero");
    a_unmapped_zero: assert property (io_rd && io_addr >= 8'h70
        |=> io_rdata == 16'h0000) else $error("unmapped read not zero");
    a_chan_fields: assert property (io_wr && io_addr == dgc_pkg::OFS_CHAN_BASE
        |=> ch_enable[0] == wd_q[7] && ch_sync_event[4:0] == wd_q[4:0])
        else $error("channel fields not taken from write");
    a_dst_const: assert property (ch_dst_const[0] == (ch_dst_mode[1:0] == dgc_pkg::AMODE_CONST))
        else $error("constant address flag wrong");
    a_dual_off: assert property (!dual_en_q && !$past(dual_en_q) |-> !dual_ram_timeout_err)
        else $error("dual port error while disabled");
    a_single_off: assert property (!single_en_q && !$past(single_en_q)
        |-> !single_ram_timeout_err) else $error("single port error while disabled");
    a_err_after_wait: assert property (dual_ram_timeout_err |-> $past(dual_ram_wait, LIMIT))
        else $error("dual error without a long wait");
    a_err_one_pulse: assert property (single_ram_timeout_err |=> !single_ram_timeout_err)
        else $error("single error longer than one cycle");
    a_dual_fires: assert property (s_dual_long_wait |-> ##[LO:HI] dual_ram_timeout_err)
        else $error("dual error missing after long wait");
endmodule

bind dgc_config dgc_props #(.NCH(NCH), .LIMIT(LIMIT)) u_props (
    .clk, .rst, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata, .io_rvalid,
    .ch_enable, .ch_dst_mode, .ch_dst_const, .ch_sync_event, .dual_ram_wait,
    .single_ram_wait, .dual_ram_timeout_err, .single_ram_timeout_err
);

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [7:0]  a;
        logic [15:0] d;
        logic [15:0] e;
    } dgc_row_t;

    // ========================================================
    // signals
    logic        clk, rst, io_wr, io_rd, io_rvalid, dual_ram_wait, single_ram_wait;
    logic        dual_ram_timeout_err, single_ram_timeout_err;
    logic [7:0]  io_addr;
    logic [2:0]  idx_chan;
    logic [15:0] io_wdata, io_rdata, src_elem_idx, src_frame_idx, dst_elem_idx, dst_frame_idx;
    logic [5:0]  ch_enable, ch_priority, ch_frame_sync, ch_auto_reload, ch_repeat;
    logic [5:0]  ch_end_prog, ch_dst_const;
    logic [11:0] ch_src_mode, ch_dst_mode;
    logic [29:0] ch_sync_event;
    int          fails, checks, cyc, dcnt, scnt;
    dgc_row_t    rows [10];

    dgc_config #(.NCH(6), .LIMIT(8)) uut (
        .clk, .rst, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata, .io_rvalid,
        .idx_chan, .src_elem_idx, .src_frame_idx, .dst_elem_idx, .dst_frame_idx,
        .ch_enable, .ch_priority, .ch_frame_sync, .ch_auto_reload, .ch_repeat,
        .ch_end_prog, .ch_dst_const, .ch_src_mode, .ch_dst_mode, .ch_sync_event,
        .dual_ram_wait, .single_ram_wait, .dual_ram_timeout_err, .single_ram_timeout_err
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // pulses are counted one edge late, which is harmless for totals
    always @(posedge clk) begin
        cyc = cyc + 1;
        dcnt = dcnt + int'(dual_ram_timeout_err);
        scnt = scnt + int'(single_ram_timeout_err);
        if (cyc == 5000) begin
            fails++;
            final_report();
        end
    end

    // ========================================================
    // tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        io_wr <= 1'b1;
        io_addr <= a;
        io_wdata <= d;
        @(posedge clk);
        io_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        io_rd <= 1'b1;
        io_addr <= a;
        @(posedge clk);
        io_rd <= 1'b0;
        #1;
        chk({15'h0000, io_rvalid}, 16'h0001);
        chk(io_rdata, e);
    endtask

    task automatic final_report();
        if (fails == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ========================================================
    // main sequence
    initial begin
        rst = 1'b1;
        {io_wr, io_rd, dual_ram_wait, single_ram_wait} = 4'h0;
        io_addr = 8'h00;
        io_wdata = 16'h0000;
        idx_chan = 3'h0;
        {fails, checks, cyc, dcnt, scnt} = '0;
        rows = '{
            '{8'h00, 16'hFFFF, 16'h0001},
            '{8'h00, 16'h0000, 16'h0000},
            '{8'h01, 16'hFFFF, 16'h0003},
            '{8'h01, 16'h0002, 16'h0002},
            '{8'h01, 16'h0001, 16'h0001},
            '{8'h40, 16'hFBFF, 16'hFBFF},
            '{8'h48, 16'h0080, 16'h0080},
            '{8'h68, 16'h5A5A, 16'h5A5A},
            '{8'hF0, 16'h1234, 16'h0000},
            '{8'h41, 16'h1111, 16'h1111}
        };
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00, 16'h0000);
        rd(8'h01, 16'h0000);
        rd(8'h40, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        chk({4'h0, ch_enable, ch_priority}, 16'h00E1);
        chk({4'h0, ch_frame_sync, ch_auto_reload}, 16'h0041);
        chk({4'h0, ch_repeat, ch_end_prog}, 16'h0861);
        chk({10'h000, ch_dst_const}, 16'h001E);
        chk({ch_dst_mode[11:10], ch_dst_mode[1:0], ch_src_mode[11:10], ch_src_mode[1:0], 8'h00},
            16'h7700);
        chk({6'h00, ch_sync_event[29:25], ch_sync_event[4:0]}, 16'h035F);
        wr(8'h51, 16'h0011);
        wr(8'h52, 16'h0022);
        wr(8'h53, 16'h0033);
        wr(8'h54, 16'h0044);
        idx_chan <= 3'h2;
        for (int m = 0; m < 2; m++) begin
            wr(8'h00, 16'(m));
            repeat (10) @(posedge clk);
            #1;
            chk(src_elem_idx, 16'h0011);
            chk(src_frame_idx, 16'h0022);
            chk(dst_elem_idx, (m == 1) ? 16'h0033 : 16'h0011);
            chk(dst_frame_idx, (m == 1) ? 16'h0044 : 16'h0022);
        end
        // k: 0 none, 1 single, 2 dual, 3 both
        for (int k = 0; k < 4; k++) begin
            wr(8'h01, 16'(k));
            dcnt = 0;
            scnt = 0;
            @(posedge clk);
            dual_ram_wait <= 1'b1;
            single_ram_wait <= 1'b1;
            repeat (30) @(posedge clk);
            dual_ram_wait <= 1'b0;
            single_ram_wait <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            chk(16'(dcnt), {15'h0000, k[1]});
            chk(16'(scnt), {15'h0000, k[0]});
        end
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'h40, 16'h0000);
        rd(8'h01, 16'h0000);
        chk({10'h000, ch_enable}, 16'h0000);
        final_report();
    end
endmodule
